// >>> ssc_select_ctrl.sv
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/10ps
// Summary of operation
// - slave, override clear: release mid byte sets fault, at a boundary clears.
// - master, override set: select output active whenever enabled.
// - master, override clear: select active only while counter nonzero.
// - slave, override set: ignore select, shift on all clocks, keep fault.
// - master, no tx data and rx space needed: start on counter write.
// - master, tx data needed: start on buffer write, count down per byte.
module ssc_select_ctrl
    import ssc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic sck_in,
    input wire logic ss_in_n,
    input wire logic sdi_in,
    output logic sck_out,
    output logic sck_oe,
    output logic ss_out_n,
    output logic sdo_out,
    output logic sdo_oe
);
    typedef enum logic [1:0] {SSC_IDLE, SSC_LOAD, SSC_SHIFT} ssc_state_e;

    ssc_link_if lnk ();

    ssc_pin_sync u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .sck_in(sck_in),
        .ss_in_n(ss_in_n),
        .sdi_in(sdi_in),
        .lnk(lnk.producer)
    );

    ////////////////////////////////////////////////////////////////////////
    // registers
    logic override_q, override_d;
    logic tx_req_q, tx_req_d;
    logic rx_req_q, rx_req_d;
    logic fault_q, fault_d;
    logic master_q, master_d;
    logic enable_q, enable_d;
    logic [7:0] count_q, count_d;
    logic [7:0] txbuf_q, txbuf_d;
    logic txfull_q, txfull_d;
    logic [7:0] rxbuf_q, rxbuf_d;
    logic [2:0] stat_q, stat_d;
    logic [2:0] mask_q, mask_d;
    logic [7:0] rdata_q, rdata_d;
    // transfer engine
    ssc_state_e state_q, state_d;
    logic [7:0] shreg_q, shreg_d;
    logic [3:0] bits_q, bits_d;
    logic [3:0] div_q, div_d;
    logic sck_q, sck_d;
    logic busy_q, busy_d;
    logic sdo_q, sdo_d;

    logic [2:0] ev;
    logic slave_sel;
    logic m_tick;
    logic do_sample;
    logic do_shift;
    logic [7:0] ctrl2_view;

    assign ctrl2_view = {busy_q, fault_q, 3'h0, override_q, tx_req_q,
                         rx_req_q};

    // slave is selected by the pin, or always when overridden
    assign slave_sel = override_q || lnk.sel_active;
    assign m_tick = (div_q == SSC_SCK_HALF);

    always_comb
    begin
        do_sample = 1'b0;
        do_shift = 1'b0;
        if (state_q == SSC_SHIFT)
        begin
            if (master_q)
            begin
                do_sample = m_tick && !sck_q;
                do_shift = m_tick && sck_q;
            end
            else if (slave_sel)
            begin
                do_sample = lnk.sck_rise;
                do_shift = lnk.sck_fall;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencing
    always_comb
    begin
        state_d = state_q;
        shreg_d = shreg_q;
        bits_d = bits_q;
        div_d = 4'h0;
        sck_d = 1'b0;
        busy_d = busy_q;
        sdo_d = sdo_q;
        count_d = count_q;
        txfull_d = txfull_q;
        rxbuf_d = rxbuf_q;
        fault_d = fault_q;
        ev = 3'h0;
        if (reg_wr && reg_addr == SSC_ADDR_COUNT)
            count_d = reg_wdata;
        if (reg_wr && reg_addr == SSC_ADDR_TXBUF)
            txfull_d = 1'b1;
        case (state_q)
            SSC_IDLE:
            begin
                busy_d = 1'b0;
                if (enable_q && master_q)
                begin
                    if (tx_req_q && txfull_q && count_q != 8'h00)
                        state_d = SSC_LOAD;
                    else if (!tx_req_q && rx_req_q && count_q != 8'h00)
                        state_d = SSC_LOAD;
                end
                else if (enable_q && slave_sel)
                    state_d = SSC_LOAD;
            end
            SSC_LOAD:
            begin
                // no transmit data needed: shift out ones
                shreg_d = (tx_req_q && txfull_q) ? txbuf_q : 8'hff;
                if (tx_req_q)
                    txfull_d = 1'b0;
                sdo_d = shreg_d[7];
                bits_d = 4'h0;
                busy_d = 1'b1;
                state_d = SSC_SHIFT;
                // release here is at a boundary; missing it would hang busy
                if (!master_q && !override_q && lnk.sel_end)
                begin
                    fault_d = 1'b0;
                    state_d = SSC_IDLE;
                end
            end
            SSC_SHIFT:
            begin
                busy_d = 1'b1;
                if (master_q)
                begin
                    div_d = m_tick ? 4'h0 : div_q + 4'h1;
                    sck_d = m_tick ? !sck_q : sck_q;
                end
                if (do_sample)
                begin
                    shreg_d = {shreg_q[6:0], lnk.sdi};
                    bits_d = bits_q + 4'h1;
                end
                if (do_shift)
                begin
                    sdo_d = shreg_q[7];
                    if (bits_q == 4'(SSC_BYTE_BITS))
                    begin
                        rxbuf_d = shreg_q;
                        ev[SSC_BIT_IRQ_RXBYTE] = 1'b1;
                        if (master_q)
                            count_d = count_q - 8'h01;
                        if (master_q && count_q == 8'h01)
                        begin
                            ev[SSC_BIT_IRQ_DONE] = 1'b1;
                            state_d = SSC_IDLE;
                        end
                        else
                            state_d = SSC_LOAD;
                    end
                end
                if (!master_q && !override_q && lnk.sel_end)
                begin
                    // release mid byte loses it; boundary is clean
                    fault_d = (bits_q != 4'h0);
                    ev[SSC_BIT_IRQ_FAULT] = (bits_q != 4'h0);
                    if (bits_q == 4'(SSC_BYTE_BITS))
                    begin
                        fault_d = 1'b0;
                        rxbuf_d = shreg_q;
                        ev[SSC_BIT_IRQ_RXBYTE] = 1'b1;
                        ev[SSC_BIT_IRQ_FAULT] = 1'b0;
                    end
                    state_d = SSC_IDLE;
                end
                if (!enable_q)
                    state_d = SSC_IDLE;
            end
            default:
                state_d = SSC_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            state_q <= SSC_IDLE;
            shreg_q <= 8'h00;
            bits_q <= 4'h0;
            div_q <= 4'h0;
            sck_q <= 1'b0;
            busy_q <= 1'b0;
            sdo_q <= 1'b1;
            count_q <= SSC_RST_COUNT;
            txfull_q <= 1'b0;
            rxbuf_q <= 8'h00;
            fault_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            shreg_q <= shreg_d;
            bits_q <= bits_d;
            div_q <= div_d;
            sck_q <= sck_d;
            busy_q <= busy_d;
            sdo_q <= sdo_d;
            count_q <= count_d;
            txfull_q <= txfull_d;
            rxbuf_q <= rxbuf_d;
            fault_q <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register port
    always_comb
    begin
        override_d = override_q;
        tx_req_d = tx_req_q;
        rx_req_d = rx_req_q;
        master_d = master_q;
        enable_d = enable_q;
        txbuf_d = txbuf_q;
        mask_d = mask_q;
        // hardware set wins over a write-one clear
        stat_d = stat_q | ev;
        rdata_d = 8'h00;
        if (reg_wr)
        begin
            case (reg_addr)
                SSC_ADDR_CTRL2:
                begin
                    // writes during busy are the caller's fault
                    override_d = reg_wdata[SSC_BIT_OVERRIDE];
                    tx_req_d = reg_wdata[SSC_BIT_TXREQ];
                    rx_req_d = reg_wdata[SSC_BIT_RXREQ];
                end
                SSC_ADDR_MODE:
                begin
                    master_d = reg_wdata[SSC_BIT_MASTER];
                    enable_d = reg_wdata[SSC_BIT_ENABLE];
                end
                SSC_ADDR_TXBUF:
                    txbuf_d = reg_wdata;
                SSC_ADDR_INT_STAT:
                    stat_d = (stat_q & ~reg_wdata[2:0]) | ev;
                SSC_ADDR_INT_MASK:
                    mask_d = reg_wdata[2:0];
                default:
                    mask_d = mask_q;
            endcase
        end
        if (reg_rd)
        begin
            case (reg_addr)
                SSC_ADDR_CTRL2:
                    rdata_d = ctrl2_view;
                SSC_ADDR_MODE:
                    rdata_d = {6'h00, enable_q, master_q};
                SSC_ADDR_COUNT:
                    rdata_d = count_q;
                SSC_ADDR_TXBUF:
                    rdata_d = txbuf_q;
                SSC_ADDR_RXBUF:
                    rdata_d = rxbuf_q;
                SSC_ADDR_INT_STAT:
                    rdata_d = {5'h00, stat_q};
                SSC_ADDR_INT_MASK:
                    rdata_d = {5'h00, mask_q};
                default:
                    rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            override_q <= SSC_RST_CTRL2[SSC_BIT_OVERRIDE];
            tx_req_q <= SSC_RST_CTRL2[SSC_BIT_TXREQ];
            rx_req_q <= SSC_RST_CTRL2[SSC_BIT_RXREQ];
            master_q <= SSC_RST_MODE[SSC_BIT_MASTER];
            enable_q <= SSC_RST_MODE[SSC_BIT_ENABLE];
            txbuf_q <= 8'h00;
            stat_q <= 3'h0;
            mask_q <= SSC_RST_MASK;
            rdata_q <= 8'h00;
        end
        else
        begin
            override_q <= override_d;
            tx_req_q <= tx_req_d;
            rx_req_q <= rx_req_d;
            master_q <= master_d;
            enable_q <= enable_d;
            txbuf_q <= txbuf_d;
            stat_q <= stat_d;
            mask_q <= mask_d;
            rdata_q <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata = rdata_q;
    assign irq = |(stat_q & mask_q);
    assign sck_out = sck_q;
    assign sck_oe = master_q && enable_q;
    assign ss_out_n = !(master_q && enable_q
                        && (override_q || count_q != 8'h00));
    assign sdo_out = sdo_q;
    // slave leaves the data line free while deselected
    assign sdo_oe = enable_q && (master_q || slave_sel);
endmodule // ssc_select_ctrl

// >>> ssc_pkg.sv
package ssc_pkg;
    // register map of the plain register port
    localparam logic [2:0] SSC_ADDR_CTRL2 = 3'h0;
    localparam logic [2:0] SSC_ADDR_MODE = 3'h1;
    localparam logic [2:0] SSC_ADDR_COUNT = 3'h2;
    localparam logic [2:0] SSC_ADDR_TXBUF = 3'h3;
    localparam logic [2:0] SSC_ADDR_RXBUF = 3'h4;
    localparam logic [2:0] SSC_ADDR_INT_STAT = 3'h5;
    localparam logic [2:0] SSC_ADDR_INT_MASK = 3'h6;
    // control register two field positions
    localparam int SSC_BIT_BUSY = 7;
    localparam int SSC_BIT_FAULT = 6;
    localparam int SSC_BIT_OVERRIDE = 2;
    localparam int SSC_BIT_TXREQ = 1;
    localparam int SSC_BIT_RXREQ = 0;
    // mode register field positions
    localparam int SSC_BIT_MASTER = 0;
    localparam int SSC_BIT_ENABLE = 1;
    // interrupt status field positions
    localparam int SSC_BIT_IRQ_DONE = 0;
    localparam int SSC_BIT_IRQ_FAULT = 1;
    localparam int SSC_BIT_IRQ_RXBYTE = 2;
    // reset values
    localparam logic [2:0] SSC_RST_CTRL2 = 3'h0;
    localparam logic [1:0] SSC_RST_MODE = 2'h0;
    localparam logic [7:0] SSC_RST_COUNT = 8'h00;
    localparam logic [2:0] SSC_RST_MASK = 3'h0;
    // serial clock divider: half period minus one, in sys_clk cycles
    localparam logic [3:0] SSC_SCK_HALF = 4'h4;
    localparam int SSC_BYTE_BITS = 8;
endpackage

// >>> ssc_link_if.sv
`timescale 1ns/10ps
interface ssc_link_if;
    logic sck_rise;
    logic sck_fall;
    logic sel_active;
    logic sel_end;
    logic sdi;
    modport producer (
        output sck_rise,
        output sck_fall,
        output sel_active,
        output sel_end,
        output sdi
    );
    modport consumer (
        input sck_rise,
        input sck_fall,
        input sel_active,
        input sel_end,
        input sdi
    );
endinterface

// >>> ssc_pin_sync.sv
`timescale 1ns/10ps
module ssc_pin_sync
    import ssc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic sck_in,
    input wire logic ss_in_n,
    input wire logic sdi_in,
    ssc_link_if.producer lnk
);
    logic [2:0] meta_q;
    logic [2:0] meta_d;
    logic [2:0] sync_q;
    logic [2:0] sync_d;
    logic [1:0] prev_q;
    logic [1:0] prev_d;

    always_comb
    begin
        meta_d = {sdi_in, ss_in_n, sck_in};
        sync_d = meta_q;
        prev_d = sync_q[1:0];
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            prev_q <= 2'h2;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign lnk.sck_rise = sync_q[0] && !prev_q[0];
    assign lnk.sck_fall = !sync_q[0] && prev_q[0];
    assign lnk.sel_active = !sync_q[1];
    assign lnk.sel_end = sync_q[1] && !prev_q[1];
    assign lnk.sdi = sync_q[2];
endmodule // ssc_pin_sync

// >>> ssc_select_ctrl_asserts.sv
`timescale 1ns/10ps
module ssc_select_ctrl_asserts (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic ss_out_n,
    input wire logic sdo_oe
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////
    chk_sel_needs_master: assert property (!ss_out_n |-> sck_oe)
        else $error("select out active outside master mode");
    chk_clock_in_frame: assert property ($rose(sck_out) |-> !ss_out_n)
        else $error("serial clock rose with select inactive");
    chk_clock_idle_low: assert property (
        ss_out_n && $past(ss_out_n) |-> !sck_out)
        else $error("serial clock high between frames");
    chk_sck_half_wide: assert property (
        $rose(sck_out) |=> sck_out [*3])
        else $error("serial clock high phase too short");
    chk_sdo_with_sck: assert property (sck_oe |-> sdo_oe)
        else $error("master without data output enable");
    chk_slave_no_clock: assert property (!sck_oe |-> !sck_out)
        else $error("serial clock toggles while not master");
    chk_read_data_window: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
endmodule // ssc_select_ctrl_asserts

bind ssc_select_ctrl ssc_select_ctrl_asserts chk_u (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .sck_out(sck_out),
    .sck_oe(sck_oe),
    .ss_out_n(ss_out_n),
    .sdo_oe(sdo_oe)
);

// >>> ssc_spi_peer.sv
`timescale 1ns/10ps
module ssc_spi_peer (
    input wire logic sck_out,
    input wire logic ss_out_n,
    input wire logic sdo_out,
    output logic sck_in,
    output logic ss_in_n,
    output logic sdi_in
);
    logic [7:0] got;
    logic [7:0] reply;
    logic [7:0] sh;
    initial
    begin
        sck_in = 1'b0;
        ss_in_n = 1'b1;
        sdi_in = 1'b0;
        got = 8'h00;
        reply = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // far-side slave: sample on rise, shift on fall
    always @(posedge sck_out)
        if (!ss_out_n)
            got = {got[6:0], sdo_out};
    always @(negedge ss_out_n)
    begin
        sh = reply;
        sdi_in = sh[7];
    end
    always @(negedge sck_out)
        if (!ss_out_n)
        begin
            sh = {sh[6:0], 1'b0};
            sdi_in = sh[7];
        end
    // no pull on the line, so a released line flips
    always @(posedge ss_out_n)
        sdi_in = ~sdi_in;
    ////////////////////////////////////////////////////////////////////////
    // far-side master: 80 ns link clock, still between frames
    task automatic send(input logic [7:0] d, input int nbits,
                        input logic use_sel);
        ss_in_n = ~use_sel;
        #40;
        for (int i = 0; i < nbits; i++)
        begin
            sdi_in = d[7-i];
            #40 sck_in = 1'b1;
            #40 sck_in = 1'b0;
        end
        #40 ss_in_n = 1'b1;
        sdi_in = ~sdi_in;
    endtask
endmodule // ssc_spi_peer

// >>> test_spi_slave_select_control.sv
`timescale 1ns/10ps
module test_spi_slave_select_control
    import ssc_pkg::*;
;
    logic sys_clk, rst_n, reg_wr, reg_rd, irq;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, rv;
    logic sck_in, ss_in_n, sdi_in, sck_out, sck_oe, ss_out_n, sdo_out, sdo_oe;
    int errors = 0;
    int checks = 0;
    ssc_select_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .sck_in(sck_in), .ss_in_n(ss_in_n), .sdi_in(sdi_in),
        .sck_out(sck_out), .sck_oe(sck_oe), .ss_out_n(ss_out_n),
        .sdo_out(sdo_out), .sdo_oe(sdo_oe));
    ssc_spi_peer peer_u (.sck_out(sck_out), .ss_out_n(ss_out_n),
        .sdo_out(sdo_out), .sck_in(sck_in), .ss_in_n(ss_in_n),
        .sdi_in(sdi_in));
    always #4 sys_clk = ~sys_clk;
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rv = reg_rdata;
    endtask
    // bounded poll; leaves the last control read in rv
    task automatic wait_idle;
        rv = 8'hff;
        for (int n = 0; n < 200 && rv[7] !== 1'b0; n++)
            rd(SSC_ADDR_CTRL2);
    endtask
    task automatic stop_test;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset_and_override;
        for (int a = 0; a < 8; a++)
            if (a != 3)
            begin
                rd(a[2:0]);
                chk(rv, 8'h00);
            end
        wr(SSC_ADDR_MODE, 8'h03);
        wr(SSC_ADDR_CTRL2, 8'h04);
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h0, ss_out_n}, 8'h00);
        wr(SSC_ADDR_CTRL2, 8'h00);
        repeat (2) @(posedge sys_clk);
        #1 chk({7'h0, ss_out_n}, 8'h01);
    endtask
    task automatic t_master_tx;
        wr(SSC_ADDR_CTRL2, 8'h02);
        wr(SSC_ADDR_INT_MASK, 8'h01);
        wr(SSC_ADDR_COUNT, 8'h01);
        repeat (3) @(posedge sys_clk);
        #1 chk({7'h0, ss_out_n}, 8'h00);
        rd(SSC_ADDR_CTRL2);
        chk(rv, 8'h02);
        wr(SSC_ADDR_TXBUF, 8'ha5);
        repeat (3) @(posedge sys_clk);
        rd(SSC_ADDR_CTRL2);
        chk(rv & 8'h80, 8'h80);
        wait_idle;
        chk(rv, 8'h02);
        chk(peer_u.got, 8'ha5);
        rd(SSC_ADDR_COUNT);
        chk(rv, 8'h00);
        chk({7'h0, ss_out_n}, 8'h01);
        chk({7'h0, irq}, 8'h01);
        wr(SSC_ADDR_INT_STAT, 8'h07);
        @(posedge sys_clk);
        #1 chk({7'h0, irq}, 8'h00);
    endtask
    task automatic t_rx_only;
        peer_u.reply = 8'h3c;
        wr(SSC_ADDR_CTRL2, 8'h01);
        wr(SSC_ADDR_COUNT, 8'h01);
        repeat (3) @(posedge sys_clk);
        rd(SSC_ADDR_CTRL2);
        chk(rv, 8'h81);
        wait_idle;
        rd(SSC_ADDR_RXBUF);
        chk(rv, 8'h3c);
        wr(SSC_ADDR_INT_MASK, 8'h00);
        @(posedge sys_clk);
        #1 chk({7'h0, irq}, 8'h00);
        wr(SSC_ADDR_INT_STAT, 8'h07);
    endtask
    task automatic t_slave;
        wr(SSC_ADDR_MODE, 8'h02);
        peer_u.send(8'h5a, 3, 1'b1);
        repeat (6) @(posedge sys_clk);
        rd(SSC_ADDR_CTRL2);
        chk(rv, 8'h41);
        rd(SSC_ADDR_INT_STAT);
        chk(rv & 8'h02, 8'h02);
        wr(SSC_ADDR_CTRL2, 8'h04);
        peer_u.send(8'hc3, 8, 1'b0);
        repeat (6) @(posedge sys_clk);
        rd(SSC_ADDR_RXBUF);
        chk(rv, 8'hc3);
        // always selected keeps busy up; leave by disabling first
        wr(SSC_ADDR_MODE, 8'h00);
        wait_idle;
        chk(rv, 8'h44);
        wr(SSC_ADDR_CTRL2, 8'h00);
        wr(SSC_ADDR_MODE, 8'h02);
        peer_u.send(8'h96, 8, 1'b1);
        repeat (6) @(posedge sys_clk);
        rd(SSC_ADDR_RXBUF);
        chk(rv, 8'h96);
        rd(SSC_ADDR_CTRL2);
        chk(rv, 8'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        t_reset_and_override;
        t_master_tx;
        t_rx_only;
        t_slave;
        stop_test;
    end
    // whole run is a few hundred cycles
    initial
    begin
        #200000;
        errors++;
        stop_test;
    end
endmodule // test_spi_slave_select_control
